/* File: logic/ocpwm_top.sv */
`timescale 1ns/10ps
`include "ocpwm_defs.svh"
module ocpwm_top #(
  parameter int UNIT_INDEX = 1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] base_timer_a,
  input  wire logic        base_timer_a_period,
  input  wire logic [15:0] base_timer_b,
  input  wire logic        base_timer_b_period,
  input  wire logic        cpu_idle,
  input  wire logic        shared_fault_input,
  output logic             compare_output_pin,
  output logic             compare_output_pin_en,
  output logic             compare_event,
  output logic             dma_request
);
  logic [15:0] control_q;
  logic [15:0] primary_q;
  logic [15:0] secondary_q;
  logic [3:0]  awaddr_q;
  logic        aw_have_q;
  logic [31:0] wdata_q;
  logic [1:0]  wstrb_q;
  logic        w_have_q;
  logic        flt_s1_q;
  logic        flt_s2_q;
  logic        ctrl_written_q;
  logic        pin;
  logic        pin_en;
  logic        evt;
  logic        fault;
  logic        do_write;
  logic        wr_ctrl;
  logic        wr_pri;
  logic        wr_sec;
  logic        wr_ok;
  logic        rd_ok;
  logic [15:0] control_rd;
  logic [31:0] rd_word;
  ocpwm_pkg::ocpwm_ctrl_s ctrl;
  ocpwm_pkg::ocpwm_base_s base;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [1:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // software must stop the time base before reconfiguring; nothing here guards it
  assign ctrl.idle_stop          = control_q[`OCPWM_BIT_IDLE_STOP];
  assign ctrl.time_base_select   = control_q[`OCPWM_BIT_TSEL];
  assign ctrl.compare_mode_field = ocpwm_pkg::ocpwm_mode_e'(control_q[2:0]);
  assign base.value      = ctrl.time_base_select ? base_timer_b : base_timer_a;
  assign base.period_hit = ctrl.time_base_select ? base_timer_b_period : base_timer_a_period;
  assign control_rd = {2'b00, control_q[13], 8'h00, fault, control_q[3:0]};

  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_ctrl  = awaddr_q == `OCPWM_ADDR_CONTROL;
  assign wr_pri   = awaddr_q == `OCPWM_ADDR_PRIMARY;
  assign wr_sec   = awaddr_q == `OCPWM_ADDR_SECONDARY;
  assign wr_ok    = wr_ctrl || wr_pri || wr_sec;
  assign rd_ok    = (s_axi_araddr == `OCPWM_ADDR_CONTROL) || (s_axi_araddr == `OCPWM_ADDR_PRIMARY) ||
                    (s_axi_araddr == `OCPWM_ADDR_SECONDARY) || (s_axi_araddr == `OCPWM_ADDR_TIMERS);
  assign rd_word  = (s_axi_araddr == `OCPWM_ADDR_CONTROL)   ? {16'h0000, control_rd} :
                    (s_axi_araddr == `OCPWM_ADDR_PRIMARY)   ? {16'h0000, primary_q} :
                    (s_axi_araddr == `OCPWM_ADDR_SECONDARY) ? {16'h0000, secondary_q} :
                    (s_axi_araddr == `OCPWM_ADDR_TIMERS)    ? {base_timer_b, base_timer_a} : 32'h0000_0000;
  ocpwm_core u_core (
    .aclk                    (aclk),
    .aresetn                 (aresetn),
    .ctrl                    (ctrl),
    .ctrl_written            (ctrl_written_q),
    .base                    (base),
    .primary_compare_value   (primary_q),
    .secondary_compare_value (secondary_q),
    .fault_sync              (flt_s2_q),
    .cpu_idle                (cpu_idle),
    .pin_q                   (pin),
    .pin_en_q                (pin_en),
    .event_q                 (evt),
    .fault_q                 (fault)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flt_s1_q <= 1'b1;
      flt_s2_q <= 1'b1;
    end else begin
      flt_s1_q <= shared_fault_input;
      flt_s2_q <= flt_s1_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 4'h0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 2'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `OCPWM_RESP_OKAY;
      control_q     <= `OCPWM_CONTROL_RESET;
      primary_q     <= 16'h0000;
      secondary_q   <= 16'h0000;
      ctrl_written_q <= 1'b0;
    end else begin
      ctrl_written_q <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q      <= {s_axi_awaddr[3:2], 2'b00};
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb[1:0];
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `OCPWM_RESP_OKAY : `OCPWM_RESP_SLVERR;
        if (wr_ctrl) begin
          control_q      <= merge16(control_q, wdata_q, wstrb_q) & `OCPWM_CONTROL_WMASK;
          ctrl_written_q <= 1'b1;
        end
        if (wr_pri) begin
          primary_q <= merge16(primary_q, wdata_q, wstrb_q);
        end
        if (wr_sec) begin
          secondary_q <= merge16(secondary_q, wdata_q, wstrb_q);
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `OCPWM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_ok ? `OCPWM_RESP_OKAY : `OCPWM_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_output_pin    <= 1'b0;
      compare_output_pin_en <= 1'b0;
      compare_event         <= 1'b0;
      dma_request           <= 1'b0;
    end else begin
      compare_output_pin    <= pin;
      compare_output_pin_en <= pin_en;
      compare_event         <= evt;
      dma_request           <= evt && (UNIT_INDEX == 1 || UNIT_INDEX == 2);
    end
  end
endmodule

/* File: logic/ocpwm_defs.svh */
// Overview of operation
// - mode 000 disables unit; pin belongs to port logic; no interrupt.
// - mode 001 starts low, interrupt on rising output edge.
// - mode 010 starts high, compare drives low, interrupt on falling edge.
// - mode 011 toggles on compare, keeps level on entry, interrupt both edges.
// - mode 100 starts low, one pulse, interrupt on its falling edge.
// - mode 101 starts low, continuous pulses, interrupt each falling edge.
// - mode 110 is PWM ignoring fault input, no interrupt.
// - PWM initial level low if primary value zero, else high.
// - mode 111 is PWM with fault input; interrupt on fault falling edge.
// - read-only fault flag bit 4 set by hardware, cleared by a control register write unless a mode 111 fault falling edge lands in the same cycle.
// - bit 3 selects timer b when set, timer a when clear.
// - bit 13 halts compare and PWM timing during CPU idle when set; mode 111 fault handling still runs.
// - pin changes on timer equal to compare value; one or two values used.
// - only units one and two may request direct memory transfers.
`ifndef OCPWM_DEFS_SVH
`define OCPWM_DEFS_SVH
`define OCPWM_ADDR_CONTROL   4'h0
`define OCPWM_ADDR_PRIMARY   4'h4
`define OCPWM_ADDR_SECONDARY 4'h8
`define OCPWM_ADDR_TIMERS    4'hC
`define OCPWM_BIT_IDLE_STOP  13
`define OCPWM_BIT_FAULT      4
`define OCPWM_BIT_TSEL       3
`define OCPWM_CONTROL_RESET  16'h0000
`define OCPWM_CONTROL_WMASK  16'h200F
`define OCPWM_RESP_OKAY      2'h0
`define OCPWM_RESP_SLVERR    2'h2
`endif

/* File: logic/ocpwm_pkg.sv */
package ocpwm_pkg;
  typedef enum logic [2:0] {
    OCPWM_OFF      = 3'b000,
    OCPWM_ONE_LOW  = 3'b001,
    OCPWM_ONE_HIGH = 3'b010,
    OCPWM_TOGGLE   = 3'b011,
    OCPWM_DELAYED  = 3'b100,
    OCPWM_CONT     = 3'b101,
    OCPWM_PWM      = 3'b110,
    OCPWM_PWM_FLT  = 3'b111
  } ocpwm_mode_e;
  typedef struct packed {
    logic        idle_stop;
    logic        time_base_select;
    ocpwm_mode_e compare_mode_field;
  } ocpwm_ctrl_s;
  typedef struct packed {
    logic [15:0] value;
    logic        period_hit;
  } ocpwm_base_s;
endpackage

/* File: logic/ocpwm_core.sv */
`timescale 1ns/10ps
`include "ocpwm_defs.svh"
module ocpwm_core (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire ocpwm_pkg::ocpwm_ctrl_s ctrl,
  input  wire logic                  ctrl_written,
  input  wire ocpwm_pkg::ocpwm_base_s base,
  input  wire logic [15:0]           primary_compare_value,
  input  wire logic [15:0]           secondary_compare_value,
  input  wire logic                  fault_sync,
  input  wire logic                  cpu_idle,
  output logic                       pin_q,
  output logic                       pin_en_q,
  output logic                       event_q,
  output logic                       fault_q
);
  logic [15:0] duty_q;
  logic        fault_prev_q;
  logic        done_q;
  logic        run;
  logic        hit_pri;
  logic        hit_sec;
  logic        fault_fall;
  logic        is_pwm;
  logic        pin_d;
  logic        done_d;
  ocpwm_pkg::ocpwm_mode_e mode;

  assign mode       = ctrl.compare_mode_field;
  assign run        = !(ctrl.idle_stop && cpu_idle);
  assign hit_pri    = run && (base.value == primary_compare_value);
  assign hit_sec    = run && (base.value == secondary_compare_value);
  assign fault_fall = fault_prev_q && !fault_sync;
  assign is_pwm     = (mode == ocpwm_pkg::OCPWM_PWM) || (mode == ocpwm_pkg::OCPWM_PWM_FLT);

  always_comb begin
    pin_d  = pin_q;
    done_d = done_q;
    case (mode)
      ocpwm_pkg::OCPWM_ONE_LOW: begin
        if (hit_pri && !done_q) begin
          pin_d  = 1'b1;
          done_d = 1'b1;
        end
      end
      ocpwm_pkg::OCPWM_ONE_HIGH: begin
        if (hit_pri && !done_q) begin
          pin_d  = 1'b0;
          done_d = 1'b1;
        end
      end
      ocpwm_pkg::OCPWM_TOGGLE: begin
        if (hit_pri) begin
          pin_d = !pin_q;
        end
      end
      ocpwm_pkg::OCPWM_DELAYED, ocpwm_pkg::OCPWM_CONT: begin
        if (!done_q && hit_pri) begin
          pin_d = 1'b1;
        end else if (pin_q && hit_sec) begin
          pin_d  = 1'b0;
          done_d = (mode == ocpwm_pkg::OCPWM_DELAYED);
        end
      end
      ocpwm_pkg::OCPWM_PWM, ocpwm_pkg::OCPWM_PWM_FLT: begin
        if (mode == ocpwm_pkg::OCPWM_PWM_FLT && (fault_q || !fault_sync)) begin
          pin_d = 1'b0;
        end else if (run && base.period_hit) begin
          pin_d = (secondary_compare_value != 16'h0000);
        end else if (run && base.value == duty_q) begin
          pin_d = 1'b0;
        end
      end
      default: begin
        pin_d  = 1'b0;
        done_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q        <= 1'b0;
      pin_en_q     <= 1'b0;
      event_q      <= 1'b0;
      fault_q      <= 1'b0;
      fault_prev_q <= 1'b1;
      done_q       <= 1'b0;
      duty_q       <= 16'h0000;
    end else begin
      fault_prev_q <= fault_sync;
      pin_en_q     <= (mode != ocpwm_pkg::OCPWM_OFF);
      if (ctrl_written) begin
        done_q  <= 1'b0;
        // a fault landing in the write cycle still sets the flag: set wins over clear
        fault_q <= (mode == ocpwm_pkg::OCPWM_PWM_FLT) && fault_fall;
        duty_q  <= primary_compare_value;
        event_q <= 1'b0;
        case (mode)
          ocpwm_pkg::OCPWM_ONE_HIGH: pin_q <= 1'b1;
          ocpwm_pkg::OCPWM_TOGGLE:   pin_q <= pin_q;
          ocpwm_pkg::OCPWM_PWM, ocpwm_pkg::OCPWM_PWM_FLT: pin_q <= (primary_compare_value != 16'h0000);
          default:                   pin_q <= 1'b0;
        endcase
      end else begin
        pin_q  <= pin_d;
        done_q <= done_d;
        if (is_pwm && run && base.period_hit) begin
          duty_q <= secondary_compare_value;
        end
        if (mode == ocpwm_pkg::OCPWM_PWM_FLT && fault_fall) begin
          fault_q <= 1'b1;
        end
        case (mode)
          ocpwm_pkg::OCPWM_ONE_LOW:  event_q <= !pin_q && pin_d;
          ocpwm_pkg::OCPWM_TOGGLE:   event_q <= pin_q != pin_d;
          ocpwm_pkg::OCPWM_ONE_HIGH, ocpwm_pkg::OCPWM_DELAYED,
          ocpwm_pkg::OCPWM_CONT:     event_q <= pin_q && !pin_d;
          ocpwm_pkg::OCPWM_PWM_FLT:  event_q <= fault_fall;
          default:                   event_q <= 1'b0;
        endcase
      end
    end
  end
endmodule

/* File: verif/ocpwm_load_model.sv */
`timescale 1ns/10ps
module ocpwm_load_model (
  input  wire logic aclk,
  input  wire logic fault_cmd,
  output logic      fault_n
);
  // the fault line has a pull-up, so it rests high between faults
  initial fault_n = 1'b1;
  always @(posedge aclk) fault_n <= !fault_cmd;
endmodule

/* File: verif/ocpwm_monitor.sv */
`timescale 1ns/10ps
module ocpwm_monitor #(
  parameter int UNIT_INDEX = 1
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        shared_fault_input,
  input wire logic        compare_output_pin,
  input wire logic        compare_output_pin_en,
  input wire logic        compare_event,
  input wire logic        dma_request
);
  logic [2:0] mode_q;
  logic [3:0] quiet_q;
  logic [3:0] flt_q;
  logic       fs_q;
  wire        wr_ctl  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 4'h0;
  // a control write lands a few cycles late, so checks wait until it settles
  wire        settled = quiet_q > 4'h3;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q  <= 3'h0;
      quiet_q <= 4'h0;
      flt_q   <= 4'h0;
      fs_q    <= 1'b0;
    end else begin
      if (wr_ctl) mode_q <= s_axi_wdata[2:0];
      quiet_q <= wr_ctl ? 4'h0 : (quiet_q == 4'hF ? quiet_q : quiet_q + 4'h1);
      flt_q   <= shared_fault_input ? 4'h0 : (flt_q == 4'hF ? flt_q : flt_q + 4'h1);
      fs_q    <= wr_ctl ? 1'b0 : (fs_q || (flt_q > 4'h5 && mode_q == 3'h7));
    end
  end
  sequence s_evt_soon;
    ##[0:1] compare_event;
  endsequence
  property p_edge_evt(hit);
    hit |-> (($past(compare_event) || $past(compare_event, 2)) or s_evt_soon);
  endproperty
  AST_EN_OWN:
    assert property (settled |-> compare_output_pin_en == (mode_q != 3'h0)) else $error("pin ownership wrong");
  AST_OFF_SILENT:
    assert property (settled && mode_q == 3'h0 |-> !compare_event) else $error("event while disabled");
  AST_PWM_SILENT:
    assert property (settled && mode_q == 3'h6 |-> !compare_event) else $error("event in plain pwm");
  AST_DMA_UNITS:
    assert property (dma_request == (compare_event && UNIT_INDEX <= 2)) else $error("dma request wrong");
  AST_RISE_EVT:
    assert property (p_edge_evt(settled && mode_q == 3'h1 && $rose(compare_output_pin))) else $error("no rise event");
  AST_FALL_EVT:
    assert property (p_edge_evt(settled && mode_q inside {3'h2, 3'h4, 3'h5} && $fell(compare_output_pin)))
    else $error("no fall event");
  AST_TOGGLE_EVT:
    assert property (p_edge_evt(settled && mode_q == 3'h3 && $changed(compare_output_pin))) else $error("no toggle event");
  AST_FAULT_EVT:
    assert property (settled && mode_q == 3'h7 && $fell(shared_fault_input) |-> ##[1:6] compare_event)
    else $error("no fault event");
  AST_FAULT_SAFE:
    assert property (settled && fs_q |-> !compare_output_pin) else $error("pin not safe after fault");
endmodule
bind ocpwm_top ocpwm_monitor #(.UNIT_INDEX(UNIT_INDEX)) i_ocpwm_monitor (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready,
  .shared_fault_input, .compare_output_pin, .compare_output_pin_en, .compare_event, .dma_request
);

/* File: verif/tb_output_compare_pwm.sv */
`timescale 1ns/10ps
`include "ocpwm_defs.svh"
module tb_output_compare_pwm;
  logic        aclk = 1'b0, aresetn = 1'b0, cpu_idle = 1'b0, flt_cmd = 1'b0, tsel = 1'b0, per = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, pin_d = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [15:0] cnt = 16'hF000, noise = 16'h8000, v;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, shared_fault_input;
  logic        compare_output_pin, compare_output_pin_en, compare_event, dma_request;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int          err_total = 0, checks_done = 0, evts = 0, rises = 0, falls = 0, e0, r0, f0;
  int          seed = 32'hAFB9;
  int          md[6] = '{2, 1, 3, 4, 5, 1};
  int          ini[6] = '{1, 0, 1, 0, 0, 0};
  int          ev[6] = '{1, 1, 2, 1, 2, 0};
  int          fin[6] = '{0, 1, 1, 0, 0, 0};
  wire [15:0]  base_timer_a = tsel ? noise : cnt;
  wire [15:0]  base_timer_b = tsel ? cnt : noise;
  wire         base_timer_a_period = per && !tsel;
  wire         base_timer_b_period = per && tsel;
  ocpwm_top #(.UNIT_INDEX(1)) i_ocpwm_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .base_timer_a, .base_timer_a_period, .base_timer_b,
    .base_timer_b_period, .cpu_idle, .shared_fault_input, .compare_output_pin, .compare_output_pin_en,
    .compare_event, .dma_request
  );
  ocpwm_load_model i_ocpwm_load_model (.aclk, .fault_cmd(flt_cmd), .fault_n(shared_fault_input));
  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    pin_d <= compare_output_pin;
    if (compare_event === 1'b1) evts <= evts + 1;
    if (compare_output_pin === 1'b1 && pin_d === 1'b0) rises <= rises + 1;
    if (compare_output_pin === 1'b0 && pin_d === 1'b1) falls <= falls + 1;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] r = `OCPWM_RESP_OKAY);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
    if (n == 40) begin
      err_total++;
      give_verdict();
    end
    @(posedge aclk);
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e, input string nm);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk(nm, {16'h0000, e}, s_axi_rdata);
    chk("rresp", {30'h0, `OCPWM_RESP_OKAY}, {30'h0, s_axi_rresp});
    if (n == 40) begin
      err_total++;
      give_verdict();
    end
    @(posedge aclk);
  endtask
  // the timer runs only inside a sweep and is parked otherwise
  task sweep(input int n, input logic p);
    for (int i = 0; i < n; i++) begin
      cnt <= 16'(i);
      noise <= 16'h8000 | 16'($random(seed));
      per <= p && (i == n - 1);
      @(posedge aclk);
    end
    cnt <= 16'hF000;
    per <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`OCPWM_ADDR_CONTROL, `OCPWM_CONTROL_RESET, "ctl_reset");
    repeat (4) begin
      v = 16'($random(seed));
      wr(`OCPWM_ADDR_CONTROL, v);
      rd(`OCPWM_ADDR_CONTROL, v & `OCPWM_CONTROL_WMASK, "ctl_mask");
    end
    wr(`OCPWM_ADDR_PRIMARY, 16'h000A);
    wr(`OCPWM_ADDR_SECONDARY, 16'h0014);
    wr(`OCPWM_ADDR_TIMERS, 16'h1234, `OCPWM_RESP_SLVERR);
    rd(`OCPWM_ADDR_PRIMARY, 16'h000A, "pri_kept");
    for (int k = 0; k < 6; k++) begin
      tsel <= k[0];
      cpu_idle <= (k == 5);
      wr(`OCPWM_ADDR_CONTROL, {2'b00, k == 5, 9'h000, k[0], md[k][2:0]});
      repeat (3) @(posedge aclk);
      chk("pin_init", ini[k], compare_output_pin);
      e0 = evts;
      sweep(30, 1'b0);
      sweep(30, 1'b0);
      chk("events", ev[k], evts - e0);
      chk("pin_end", fin[k], compare_output_pin);
      chk("pin_en", 1, compare_output_pin_en);
    end
    cpu_idle <= 1'b0;
    tsel <= 1'b0;
    wr(`OCPWM_ADDR_CONTROL, 16'h0000);
    e0 = evts;
    sweep(30, 1'b0);
    chk("off_en", 0, compare_output_pin_en);
    chk("off_events", 0, evts - e0);
    wr(`OCPWM_ADDR_PRIMARY, 16'h0000);
    wr(`OCPWM_ADDR_CONTROL, 16'h0006);
    repeat (3) @(posedge aclk);
    chk("pwm_init_low", 0, compare_output_pin);
    wr(`OCPWM_ADDR_PRIMARY, 16'h0005);
    wr(`OCPWM_ADDR_SECONDARY, 16'h00FF);
    wr(`OCPWM_ADDR_CONTROL, 16'h0006);
    repeat (3) @(posedge aclk);
    chk("pwm_init_high", 1, compare_output_pin);
    e0 = evts;
    r0 = rises;
    f0 = falls;
    sweep(10, 1'b1);
    sweep(10, 1'b1);
    chk("pwm_rises", 1, rises - r0);
    chk("pwm_falls", 1, falls - f0);
    chk("pwm_events", 0, evts - e0);
    wr(`OCPWM_ADDR_CONTROL, 16'h0007);
    repeat (3) @(posedge aclk);
    e0 = evts;
    flt_cmd <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("fault_pin", 0, compare_output_pin);
    rd(`OCPWM_ADDR_CONTROL, 16'h0017, "fault_flag");
    flt_cmd <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("fault_hold", 0, compare_output_pin);
    chk("fault_events", 1, evts - e0);
    wr(`OCPWM_ADDR_CONTROL, 16'h0007);
    repeat (3) @(posedge aclk);
    chk("fault_release", 1, compare_output_pin);
    rd(`OCPWM_ADDR_CONTROL, 16'h0007, "fault_clear");
    give_verdict();
  end
endmodule
